// File: hw/bsad_boot_decode.sv
// Boot section, read section and pointer decode for flash self-programming
module bsad_boot_decode
  import bsad_pkg::*;
#(
  parameter bit LARGE = 1'b0
) (
  // Clock, reset and enable
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Boot size fuse cells (pins)
  input  wire logic              boot_size_sel_hi,
  input  wire logic              boot_size_sel_lo,
  // CPU store and load requests
  input  wire bsad_store_t       store_in,
  input  wire bsad_load_t        load_in,
  // CPU instruction fetch check
  input  wire logic              fetch_req,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  // Flash array answers
  input  wire logic [15:0]       flash_rdata,
  input  wire logic              flash_done,
  // Section decode results
  output bsad_sect_t             sect_out,
  output logic [1:0]             fuse_read,
  output logic [ADDR_W-1:0]      blocking_start,
  // Fetch answer
  output logic                   fetch_ok,
  output logic                   fetch_in_boot,
  // Page buffer fill
  output logic                   buf_we,
  output logic [WIDX_W-1:0]      buf_word,
  output logic [15:0]            buf_wdata,
  // Page operations
  output logic                   pg_erase,
  output logic                   pg_write,
  output logic [PAGE_W-1:0]      pg_num,
  output logic                   op_busy,
  output logic                   rww_busy,
  output logic                   store_refused,
  // Flash read for loads
  output logic                   flash_rd,
  output logic [ADDR_W-1:0]      flash_raddr,
  output logic                   load_valid,
  output logic [7:0]             load_byte
);

  localparam logic [ADDR_W-1:0] BLOCK_START = LARGE ? BLOCKING_START_LARGE : BLOCKING_START_SMALL;

  // Boot start from fuse pair
  function automatic logic [ADDR_W-1:0] boot_start_of(input logic [1:0] sel);
    logic [ADDR_W-1:0] r;
    r = ADDR_RESET;
    if (LARGE) begin
      case (sel)
        2'h3:    r = BOOT_START_LARGE_11;
        2'h2:    r = BOOT_START_LARGE_10;
        2'h1:    r = BOOT_START_LARGE_01;
        default: r = BOOT_START_LARGE_00;
      endcase
    end else begin
      case (sel)
        2'h3:    r = BOOT_START_SMALL_11;
        2'h2:    r = BOOT_START_SMALL_10;
        2'h1:    r = BOOT_START_SMALL_01;
        default: r = BOOT_START_SMALL_00;
      endcase
    end
    return r;
  endfunction

  // Word address from byte pointer; bits above range dropped
  function automatic logic [ADDR_W-1:0] word_of(input logic [PTR_W-1:0] p);
    logic [ADDR_W-1:0] r;
    r = ADDR_RESET;
    if (LARGE) begin
      r = p[POINTER_COUNTER_TOP_BIT_LARGE:1];
    end else begin
      r = {1'b0, p[POINTER_COUNTER_TOP_BIT_SMALL:1]};
    end
    return r;
  endfunction

  // Concurrent read section membership
  function automatic logic in_concurrent(input logic [ADDR_W-1:0] a);
    return a < BLOCK_START;
  endfunction

  logic [1:0]        fuse_sync;
  bsad_state_t       state_reg;
  bsad_state_t       state_next;
  logic              lock_reg;
  logic              load_pend_reg;
  logic              load_sel_reg;
  logic              load_block_reg;
  logic [ADDR_W-1:0] boot_start_w;
  logic [PAGE_W-1:0] store_page;
  logic [WIDX_W-1:0] store_widx;
  logic [ADDR_W-1:0] load_word;
  logic              start_erase;
  logic              start_write;
  logic              reenable;
  logic              refuse;

  bsad_sync3 #(
    .W     (2),
    .RESET (FUSE_RESET)
  ) u_fuse_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({boot_size_sel_hi, boot_size_sel_lo}),
    .sync_out (fuse_sync)
  );

  assign boot_start_w = boot_start_of(fuse_sync);
  assign load_word    = word_of(load_in.ptr);

  // Page and word fields of the pointer
  always_comb begin
    if (LARGE) begin
      store_page = store_in.ptr[POINTER_COUNTER_TOP_BIT_LARGE:POINTER_IN_PAGE_TOP_BIT_LARGE+1];
      store_widx = store_in.ptr[POINTER_IN_PAGE_TOP_BIT_LARGE:1];
    end else begin
      store_page = store_in.ptr[POINTER_COUNTER_TOP_BIT_SMALL:POINTER_IN_PAGE_TOP_BIT_SMALL+1];
      store_widx = {1'b0, store_in.ptr[POINTER_IN_PAGE_TOP_BIT_SMALL:1]};
    end
  end

  // Command qualification
  always_comb begin
    start_erase = 1'b0;
    start_write = 1'b0;
    reenable    = 1'b0;
    refuse      = 1'b0;
    if (store_in.valid) begin
      if (state_reg != BSAD_IDLE) begin
        refuse = 1'b1;
      end else begin
        case (store_in.op)
          BSAD_OP_ERASE:    start_erase = 1'b1;
          BSAD_OP_WRITE:    start_write = 1'b1;
          BSAD_OP_REENABLE: reenable    = 1'b1;
          default:          ;
        endcase
      end
    end
  end

  // Page operation sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BSAD_IDLE: begin
        if (start_erase) begin
          state_next = BSAD_ERASING;
        end else if (start_write) begin
          state_next = BSAD_WRITING;
        end
      end
      BSAD_ERASING: begin
        if (flash_done) begin
          state_next = BSAD_IDLE;
        end
      end
      BSAD_WRITING: begin
        if (flash_done) begin
          state_next = BSAD_IDLE;
        end
      end
      default: state_next = BSAD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BSAD_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Concurrent section lock; a new erase or write wins over re-enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_erase || start_write) begin
        lock_reg <= 1'b1;
      end else if (reenable) begin
        lock_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_busy       <= 1'b0;
      rww_busy      <= 1'b0;
      store_refused <= 1'b0;
    end else if (clk_en) begin
      op_busy       <= (state_next != BSAD_IDLE);
      rww_busy      <= (start_erase || start_write) || (lock_reg && !reenable);
      store_refused <= refuse;
    end
  end

  // Section decode, refreshed every enabled cycle from the filtered fuses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sect_out.boot_start   <= ADDR_RESET;
      sect_out.app_end      <= ADDR_RESET;
      sect_out.reset_vector <= ADDR_RESET;
      fuse_read             <= FUSE_RESET;
      blocking_start        <= ADDR_RESET;
    end else if (clk_en) begin
      sect_out.boot_start   <= boot_start_w;
      sect_out.app_end      <= boot_start_w - ONE_WORD;
      sect_out.reset_vector <= boot_start_w;
      fuse_read             <= fuse_sync;
      blocking_start        <= BLOCK_START;
    end
  end

  // Fetch check; fetches into the concurrent section blocked while it is locked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ok      <= 1'b0;
      fetch_in_boot <= 1'b0;
    end else if (clk_en) begin
      fetch_ok      <= fetch_req && !(lock_reg && in_concurrent(fetch_addr));
      fetch_in_boot <= fetch_req && (fetch_addr >= boot_start_w);
    end
  end

  // Buffer fill; word field only, page bits are the page command's job
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_we    <= 1'b0;
      buf_word  <= '0;
      buf_wdata <= WORD_RESET;
    end else if (clk_en) begin
      buf_we <= store_in.valid && (state_reg == BSAD_IDLE) && (store_in.op == BSAD_OP_FILL);
      // Refused fills leave the held word and data alone
      if (store_in.valid && (state_reg == BSAD_IDLE) && (store_in.op == BSAD_OP_FILL)) begin
        buf_word  <= store_widx;
        buf_wdata <= store_in.data;
      end
    end
  end

  // Page erase and write strobes with page number
  // Word bits are not examined for write: software keeps them zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pg_erase <= 1'b0;
      pg_write <= 1'b0;
      pg_num   <= '0;
    end else if (clk_en) begin
      pg_erase <= start_erase;
      pg_write <= start_write;
      if (start_erase || start_write) begin
        pg_num <= store_page;
      end
    end
  end

  // Load stage one: issue flash read, remember byte select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_rd       <= 1'b0;
      flash_raddr    <= ADDR_RESET;
      load_pend_reg  <= 1'b0;
      load_sel_reg   <= 1'b0;
      load_block_reg <= 1'b0;
    end else if (clk_en) begin
      flash_rd      <= load_in.valid && !(lock_reg && in_concurrent(load_word));
      load_pend_reg <= load_in.valid;
      if (load_in.valid) begin
        flash_raddr    <= load_word;
        load_sel_reg   <= load_in.ptr[0];
        load_block_reg <= lock_reg && in_concurrent(load_word);
      end
    end
  end

  // Load stage two: pick the byte of the returned word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_valid <= 1'b0;
      load_byte  <= 8'h00;
    end else if (clk_en) begin
      load_valid <= load_pend_reg;
      if (load_pend_reg) begin
        if (load_block_reg) begin
          load_byte <= BLOCKED_BYTE;
        end else if (load_sel_reg) begin
          load_byte <= flash_rdata[15:8];
        end else begin
          load_byte <= flash_rdata[7:0];
        end
      end
    end
  end

endmodule // bsad_boot_decode

// File: hw/bsad_sync3.sv
// Three-stage input synchroniser with agreement filter
module bsad_sync3
  import bsad_pkg::*;
#(
  parameter int unsigned      W     = 2,
  parameter logic [W-1:0]     RESET = '1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Asynchronous input and filtered output
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RESET;
      s2_reg <= RESET;
      s3_reg <= RESET;
    end else if (clk_en) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only stages two and three are compared; stage one may be metastable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= RESET;
    end else if (clk_en && (s2_reg == s3_reg)) begin
      sync_out <= s3_reg;
    end
  end

endmodule // bsad_sync3

// File: inc/bsad_pkg.sv
// Package of constants and carrier types for boot section address decode
// How it works
// - Small variant fuses pick 128..1024-word boot
// - Large variant fuses pick boot start 0x1F80..0x1C00
// - Application ends below boot; reset vector equals start
// - Small variant concurrent section fixed 0x000-0xBFF
// - Large variant concurrent section fixed 0x0000-0x1BFF
// - Small variant: 12-bit counter, 32-word pages
// - Large variant: counter top bit 12, 64-word pages
// - Pointer is byte address, word bit n at n+1
// - Page number from pointer 12:6 or 13:7
// - Buffer word from pointer 5:1 or 6:1
// - Pointer bits above flash range are ignored
// - Load uses pointer bit 0 as byte select
// - Programmed fuse reads zero, unprogrammed reads one
// - During erase/write only blocking section is readable
package bsad_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned PTR_W  = 16;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned WIDX_W = 6;

  // Boot section starts, indexed by fuse pair
  localparam logic [12:0] BOOT_START_SMALL_11 = 13'h0F80;
  localparam logic [12:0] BOOT_START_SMALL_10 = 13'h0F00;
  localparam logic [12:0] BOOT_START_SMALL_01 = 13'h0E00;
  localparam logic [12:0] BOOT_START_SMALL_00 = 13'h0C00;
  localparam logic [12:0] BOOT_START_LARGE_11 = 13'h1F80;
  localparam logic [12:0] BOOT_START_LARGE_10 = 13'h1F00;
  localparam logic [12:0] BOOT_START_LARGE_01 = 13'h1E00;
  localparam logic [12:0] BOOT_START_LARGE_00 = 13'h1C00;
  localparam logic [12:0] ONE_WORD            = 13'h0001;

  // Fixed split between concurrent and blocking read sections
  localparam logic [12:0] BLOCKING_START_SMALL = 13'h0C00;
  localparam logic [12:0] BLOCKING_START_LARGE = 13'h1C00;
  localparam logic [12:0] FLASH_TOP_SMALL      = 13'h0FFF;
  localparam logic [12:0] FLASH_TOP_LARGE      = 13'h1FFF;
  localparam int unsigned CONCURRENT_PAGES_SMALL = 96;
  localparam int unsigned CONCURRENT_PAGES_LARGE = 112;
  localparam int unsigned BLOCKING_PAGES_SMALL   = 32;
  localparam int unsigned BLOCKING_PAGES_LARGE   = 16;

  // Field positions
  localparam int unsigned COUNTER_TOP_BIT_SMALL         = 11;
  localparam int unsigned COUNTER_TOP_BIT_LARGE         = 12;
  localparam int unsigned IN_PAGE_TOP_BIT_SMALL         = 4;
  localparam int unsigned IN_PAGE_TOP_BIT_LARGE         = 5;
  localparam int unsigned POINTER_COUNTER_TOP_BIT_SMALL = 12;
  localparam int unsigned POINTER_COUNTER_TOP_BIT_LARGE = 13;
  localparam int unsigned POINTER_IN_PAGE_TOP_BIT_SMALL = 5;
  localparam int unsigned POINTER_IN_PAGE_TOP_BIT_LARGE = 6;

  // Reset values and blocked-load byte
  localparam logic [1:0]  FUSE_RESET    = 2'h3;
  localparam logic [7:0]  BLOCKED_BYTE  = 8'hFF;
  localparam logic [12:0] ADDR_RESET    = 13'h0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  typedef enum logic [1:0] {
    BSAD_OP_FILL,
    BSAD_OP_ERASE,
    BSAD_OP_WRITE,
    BSAD_OP_REENABLE
  } bsad_op_t;

  typedef enum logic [1:0] {
    BSAD_IDLE,
    BSAD_ERASING,
    BSAD_WRITING
  } bsad_state_t;

  typedef struct packed {
    logic             valid;
    bsad_op_t         op;
    logic [PTR_W-1:0] ptr;
    logic [15:0]      data;
  } bsad_store_t;

  typedef struct packed {
    logic             valid;
    logic [PTR_W-1:0] ptr;
  } bsad_load_t;

  typedef struct packed {
    logic [ADDR_W-1:0] boot_start;
    logic [ADDR_W-1:0] app_end;
    logic [ADDR_W-1:0] reset_vector;
  } bsad_sect_t;

endpackage

// File: testbench/bsad_boot_decode_asserts.sv
// Concurrent checks on the boot section decode ports
module bsad_boot_decode_asserts
  import bsad_pkg::*;
#(
  parameter bit LARGE = 1'b0
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              clk_en,
  // Requests
  input wire bsad_store_t       store_in,
  input wire bsad_load_t        load_in,
  input wire logic              fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic [15:0]       flash_rdata,
  // Results
  input wire bsad_sect_t        sect_out,
  input wire logic [1:0]        fuse_read,
  input wire logic [ADDR_W-1:0] blocking_start,
  input wire logic              fetch_ok,
  input wire logic              buf_we,
  input wire logic [WIDX_W-1:0] buf_word,
  input wire logic              pg_erase,
  input wire logic              pg_write,
  input wire logic [PAGE_W-1:0] pg_num,
  input wire logic              op_busy,
  input wire logic              rww_busy,
  input wire logic              store_refused,
  input wire logic              flash_rd,
  input wire logic [ADDR_W-1:0] flash_raddr,
  input wire logic              load_valid,
  input wire logic [7:0]        load_byte
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] st_q, ld_q1, ld_q2, rd_q;
  // Request history, so slices need no $past
  always_ff @(posedge clock) begin
    st_q  <= store_in.ptr;
    ld_q1 <= load_in.ptr;
    ld_q2 <= ld_q1;
    rd_q  <= flash_rdata;
  end
  function automatic logic [12:0] bstart(logic [1:0] f);
    return (LARGE ? 13'h1FFF : 13'h0FFF) + 13'h0001 - (13'h0080 << (2'h3 - f));
  endfunction
  sequence fill_s; clk_en && store_in.valid && store_in.op == BSAD_OP_FILL && !op_busy; endsequence
  sequence page_s; clk_en && store_in.valid && !op_busy && store_in.op inside {BSAD_OP_ERASE, BSAD_OP_WRITE}; endsequence
  sequence load_s; clk_en && load_in.valid; endsequence
  chk_app_pairing: assert property (
    sect_out.boot_start != '0 |-> sect_out.app_end == sect_out.boot_start - 13'h0001
      && sect_out.reset_vector == sect_out.boot_start) else $error("application end or vector off");
  chk_boot_table: assert property (
    sect_out.boot_start != '0 && $stable(fuse_read) |-> sect_out.boot_start == bstart(fuse_read))
    else $error("boot start does not follow fuses");
  chk_split_fixed: assert property (
    blocking_start != '0 |-> blocking_start == (LARGE ? 13'h1C00 : 13'h0C00)) else $error("split moved");
  chk_fill_word: assert property (
    fill_s |=> buf_we && buf_word == (LARGE ? st_q[6:1] : {1'b0, st_q[5:1]})) else $error("fill word wrong");
  chk_page_start: assert property (
    page_s |=> (pg_erase ^ pg_write) && op_busy && rww_busy && pg_num == (LARGE ? st_q[13:7] : st_q[12:6]))
    else $error("page operation wrong");
  chk_busy_refuse: assert property (
    clk_en && store_in.valid && op_busy |=> store_refused && !buf_we && !pg_erase && !pg_write)
    else $error("store taken while busy");
  chk_load_path: assert property (
    load_s and (!rww_busy) |=> flash_rd && flash_raddr == (LARGE ? ld_q1[13:1] : {1'b0, ld_q1[12:1]}) ##1 load_valid)
    else $error("load address wrong");
  chk_byte_select: assert property (
    load_valid && $past(flash_rd) |-> load_byte == (ld_q2[0] ? rd_q[15:8] : rd_q[7:0]))
    else $error("load byte wrong");
  chk_locked_load: assert property (
    load_s and (rww_busy && (LARGE ? load_in.ptr[13:1] : {1'b0, load_in.ptr[12:1]}) < blocking_start)
      |=> !flash_rd ##1 load_valid && load_byte == BLOCKED_BYTE) else $error("locked load read flash");
  chk_fetch_lock: assert property (
    clk_en && fetch_req |=> fetch_ok == (!$past(rww_busy) || $past(fetch_addr) >= $past(blocking_start)))
    else $error("fetch answer wrong");
endmodule // bsad_boot_decode_asserts

// File: testbench/bsad_boot_decode_test.sv
// Self-checking bench running both size variants side by side
module bsad_boot_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bsad_pkg::*;
  logic              clock, rst_n, clk_en, fz_hi, fz_lo, fetch_req;
  logic [ADDR_W-1:0] fetch_addr, a;
  bsad_store_t       store_in;
  bsad_load_t        load_in;
  bsad_sect_t        sect_o [2];
  logic [1:0]        fuse_o [2];
  logic [ADDR_W-1:0] blk_o [2], raddr_o [2];
  logic              bwe_o [2], er_o [2], wr_o [2], busy_o [2], rww_o [2], ref_o [2], rd_o [2], lv_o [2];
  logic              fok_o [2], done_o [2], fib_o [2];
  logic [WIDX_W-1:0] bw_o [2];
  logic [15:0]       bd_o [2], rdat_o [2], p, d, w;
  logic [PAGE_W-1:0] pg_o [2];
  logic [7:0]        lb_o [2];
  int                miscompares, comparisons, seed, e;
  for (genvar g = 0; g < 2; g++) begin : vg
    bsad_boot_decode #(.LARGE(g == 1)) uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .boot_size_sel_hi(fz_hi), .boot_size_sel_lo(fz_lo), .store_in(store_in), .load_in(load_in),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr), .flash_rdata(rdat_o[g]), .flash_done(done_o[g]),
      .sect_out(sect_o[g]), .fuse_read(fuse_o[g]), .blocking_start(blk_o[g]), .fetch_ok(fok_o[g]),
      .fetch_in_boot(fib_o[g]), .buf_we(bwe_o[g]), .buf_word(bw_o[g]), .buf_wdata(bd_o[g]), .pg_erase(er_o[g]),
      .pg_write(wr_o[g]), .pg_num(pg_o[g]), .op_busy(busy_o[g]), .rww_busy(rww_o[g]), .store_refused(ref_o[g]),
      .flash_rd(rd_o[g]), .flash_raddr(raddr_o[g]), .load_valid(lv_o[g]), .load_byte(lb_o[g]));
    // Prompt and slow completion, one per variant
    bsad_flash_model #(.DONE_DELAY(g == 1 ? 60 : 12)) flash (.clock(clock), .rst_n(rst_n), .flash_rd(rd_o[g]),
      .flash_raddr(raddr_o[g]), .flash_rdata(rdat_o[g]), .pg_erase(er_o[g]), .pg_write(wr_o[g]),
      .flash_done(done_o[g]));
  end
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Valid stays up; caller lowers it, so back-to-back stores are possible
  task automatic store(input bsad_op_t op, input logic [15:0] ptr, input logic [15:0] dat);
    store_in = '{1'b1, op, ptr, dat};
    nx(1);
  endtask
  task automatic load(input logic [15:0] ptr);
    load_in = '{1'b1, ptr};
    nx(1);
    load_in.valid = 1'b0;
  endtask
  task automatic fetch(input logic [ADDR_W-1:0] adr, input logic exp, input logic inb);
    fetch_req  = 1'b1;
    fetch_addr = adr;
    nx(1);
    for (int g = 0; g < 2; g++) begin
      cmp_flag(fok_o[g], exp);
      cmp_flag(fib_o[g], inb);
    end
  endtask
  task automatic wait_idle;
    for (e = 0; e < 300 && (busy_o[0] !== 1'b0 || busy_o[1] !== 1'b0); e++) nx(1);
    if (e == 300) begin
      miscompares++;
      close_out();
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    seed       = 63;
    rst_n      = 1'b0;
    clk_en     = 1'b1;
    fz_hi      = 1'b1;
    fz_lo      = 1'b1;
    fetch_req  = 1'b0;
    fetch_addr = '0;
    store_in   = '0;
    load_in    = '0;
    nx(6);
    for (int g = 0; g < 2; g++) cmp_val(fuse_o[g], 16'h0003);
    rst_n = 1'b1;
    for (int f = 3; f >= 0; f--) begin
      {fz_hi, fz_lo} = f[1:0];
      nx(10);
      for (int g = 0; g < 2; g++) begin
        e = (g ? 'h2000 : 'h1000) - (128 << (3 - f));
        cmp_val(sect_o[g].boot_start, e);
        cmp_val(sect_o[g].app_end, e - 1);
        cmp_val(sect_o[g].reset_vector, e);
        cmp_val(blk_o[g], g ? 16'h1C00 : 16'h0C00);
        cmp_val(fuse_o[g], f);
      end
    end
    repeat (8) begin
      p = $random(seed) & 16'hFFFE;
      d = $random(seed);
      store(BSAD_OP_FILL, p, d);
      for (int g = 0; g < 2; g++) begin
        cmp_flag(bwe_o[g], 1'b1);
        cmp_val(bw_o[g], g ? p[6:1] : p[5:1]);
        cmp_val(bd_o[g], d);
      end
    end
    // Frozen enable must hold the last fill
    clk_en         = 1'b0;
    store_in.valid = 1'b0;
    nx(2);
    for (int g = 0; g < 2; g++) begin
      cmp_flag(bwe_o[g], 1'b1);
      cmp_val(bd_o[g], d);
    end
    clk_en = 1'b1;
    repeat (8) begin
      p = $random(seed);
      load(p);
      for (int g = 0; g < 2; g++) begin
        cmp_val(raddr_o[g], g ? p[13:1] : p[12:1]);
        cmp_flag(rd_o[g], 1'b1);
      end
      nx(1);
      for (int g = 0; g < 2; g++) begin
        a = g ? p[13:1] : {1'b0, p[12:1]};
        w = {a[7:0] ^ 8'h5A, a[12:5]};
        cmp_flag(lv_o[g], 1'b1);
        cmp_val(lb_o[g], p[0] ? w[15:8] : w[7:0]);
      end
    end
    p = $random(seed) & 16'hFFFE;
    store(BSAD_OP_ERASE, p, 16'h0000);
    store_in.valid = 1'b0;
    for (int g = 0; g < 2; g++) begin
      cmp_flag(er_o[g], 1'b1);
      cmp_val(pg_o[g], g ? p[13:7] : p[12:6]);
      cmp_flag(rww_o[g], 1'b1);
      cmp_flag(busy_o[g], 1'b1);
    end
    nx(1);
    store(BSAD_OP_FILL, 16'h0002, 16'h1234);
    store_in.valid = 1'b0;
    for (int g = 0; g < 2; g++) begin
      cmp_flag(ref_o[g] & ~bwe_o[g], 1'b1);
      cmp_val(bd_o[g], d);
    end
    load(16'h0100);
    for (int g = 0; g < 2; g++) cmp_flag(rd_o[g], 1'b0);
    nx(1);
    for (int g = 0; g < 2; g++) cmp_val(lb_o[g], 8'hFF);
    fetch(13'h0010, 1'b0, 1'b0);
    fetch(13'h1FFF, 1'b1, 1'b1);
    fetch_req = 1'b0;
    wait_idle();
    store(BSAD_OP_REENABLE, 16'h0000, 16'h0000);
    store_in.valid = 1'b0;
    for (int g = 0; g < 2; g++) cmp_flag(rww_o[g], 1'b0);
    fetch(13'h0010, 1'b1, 1'b0);
    fetch_req = 1'b0;
    p = $random(seed) & 16'hFF80;
    store(BSAD_OP_WRITE, p, 16'h0000);
    store_in.valid = 1'b0;
    for (int g = 0; g < 2; g++) begin
      cmp_flag(wr_o[g], 1'b1);
      cmp_val(pg_o[g], g ? p[13:7] : p[12:6]);
    end
    wait_idle();
    close_out();
  end
endmodule // bsad_boot_decode_test
bind bsad_boot_decode bsad_boot_decode_asserts #(.LARGE(LARGE)) chk (.clock(clock), .rst_n(rst_n),
  .clk_en(clk_en), .store_in(store_in), .load_in(load_in), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .flash_rdata(flash_rdata), .sect_out(sect_out), .fuse_read(fuse_read), .blocking_start(blocking_start),
  .fetch_ok(fetch_ok), .buf_we(buf_we), .buf_word(buf_word), .pg_erase(pg_erase), .pg_write(pg_write),
  .pg_num(pg_num), .op_busy(op_busy), .rww_busy(rww_busy), .store_refused(store_refused), .flash_rd(flash_rd),
  .flash_raddr(flash_raddr), .load_valid(load_valid), .load_byte(load_byte));

// File: testbench/bsad_flash_model.sv
// Flash array model: read data and slow erase or write completion
module bsad_flash_model
  import bsad_pkg::*;
#(
  parameter int DONE_DELAY = 12
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Read port
  input  wire logic              flash_rd,
  input  wire logic [ADDR_W-1:0] flash_raddr,
  output logic      [15:0]       flash_rdata,
  // Page operations
  input  wire logic              pg_erase,
  input  wire logic              pg_write,
  output logic                   flash_done
);
  int          count;
  logic [15:0] junk;
  // Idle data toggles so a stale read cannot pass by luck
  assign flash_rdata = flash_rd ? {flash_raddr[7:0] ^ 8'h5A, flash_raddr[12:5]} : junk;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count      <= 0;
      flash_done <= 1'b0;
      junk       <= 16'hA5A5;
    end else begin
      junk       <= ~junk;
      flash_done <= (count == 1);
      if (pg_erase || pg_write) begin
        count <= DONE_DELAY;
      end else if (count != 0) begin
        count <= count - 1;
      end
    end
  end
endmodule // bsad_flash_model
